// ---- common/fsh_pkg.sv ----
// Constants, types and helpers shared by the flash save command handler.
package fsh_pkg;

   localparam longint unsigned CLK_HZ       = 100_000_000;
   localparam longint unsigned SAVE_MAX_S   = 30;
   localparam logic [31:0]     SAVE_MAX_CYC = 32'(SAVE_MAX_S * CLK_HZ);

   localparam logic [15:0] CODE_SAVE_POS   = 16'h17d4;
   localparam logic [15:0] CODE_SAVE_PARAM = 16'h17d5;
   localparam logic [15:0] SAVE_WORD_COUNT = 16'h0002;
   localparam logic [15:0] SRC_WORD_LO     = 16'h0001;
   localparam logic [15:0] SRC_WORD_HI     = 16'h0000;
   localparam logic [15:0] UNIT_MAX_2AX    = 16'h005d;
   localparam logic [15:0] UNIT_MAX_4AX    = 16'h005b;
   localparam logic [15:0] AREA_BASE       = 16'h07d0;
   localparam logic [15:0] AREA_STEP       = 16'h000a;
   localparam logic [7:0]  AREA_WORDS_4AX  = 8'h32;
   localparam logic [7:0]  AREA_WORDS_2AX  = 8'h1e;
   localparam logic [10:0] POS_TABLE_LAST  = 11'h7cf;
   localparam int          STAT_ERR_BIT    = 14;

   localparam logic [7:0] REG_CFG      = 8'h00;
   localparam logic [7:0] REG_STATUS   = 8'h04;
   localparam logic [7:0] REG_ERRCODE  = 8'h08;
   localparam logic [7:0] REG_AREA     = 8'h0c;
   localparam logic [7:0] REG_IRQ_STAT = 8'h10;
   localparam logic [7:0] REG_IRQ_MASK = 8'h14;

   localparam logic [6:0]  CFG_UNIT_RST  = 7'h00;
   localparam logic        CFG_4AX_RST   = 1'b1;
   localparam int          CFG_4AX_BIT   = 8;
   localparam logic [1:0]  IRQ_MASK_RST  = 2'h0;
   localparam int          IRQ_DONE_BIT  = 0;
   localparam int          IRQ_ERR_BIT   = 1;

   localparam logic [15:0] ERR_NONE      = 16'h0000;
   localparam logic [15:0] ERR_SRC_RANGE = 16'h0001;
   localparam logic [15:0] ERR_TIMEOUT   = 16'h0002;

   typedef enum logic [1:0] {
      REGION_POSITION = 2'h0,
      REGION_PARAM    = 2'h1,
      REGION_PROGRAM  = 2'h2
   } fsh_region_type;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_CHECK = 3'b010,
      ST_SAVE  = 3'b100
   } fsh_state_type;

   function automatic logic is_save_code(input logic [15:0] code);
      return (code == CODE_SAVE_POS) || (code == CODE_SAVE_PARAM);
   endfunction

endpackage

// ---- src/fsh_area_map.sv ----
// Interface-area placement: first word and word count for the configured unit.
`timescale 1ns/1ps
module fsh_area_map
   import fsh_pkg::*;
(
   input  wire logic [6:0]  unit_num,   // Configured unit number.
   input  wire logic        four_axis,  // High for the four-axis model.
   output logic      [15:0] area_first, // First allocated interface word.
   output logic      [7:0]  area_words, // Number of allocated words.
   output logic      [15:0] unit_max    // Highest legal destination unit.
);

   always_comb begin
      area_first = 16'(AREA_BASE + AREA_STEP * {9'h000, unit_num}); // RULE_08
      area_words = four_axis ? AREA_WORDS_4AX : AREA_WORDS_2AX;     // RULE_09
      unit_max   = four_axis ? UNIT_MAX_4AX : UNIT_MAX_2AX;
   end

endmodule

// ---- src/fsh_cmd_handler.sv ----
// Flash save command handler with APB registers and interface-area status.
`timescale 1ns/1ps
// Overview of operation
// (RULE_01) Code 17d4 saves position data to flash.
// (RULE_02) Code 17d5 saves system parameters to flash.
// (RULE_03) Host sends unit low, count 0002 high.
// (RULE_04) Unit at most 005d two-axis, 005b four-axis.
// (RULE_05) Source words must read 0001 then 0000.
// (RULE_06) Host saves only when idle and axes still.
// (RULE_07) Save may last up to 30 seconds.
// (RULE_08) First interface word is 2000 plus ten times unit.
// (RULE_09) Area is 50 words four-axis, 30 two-axis.
// (RULE_10) Interface area carries commands in, status out.
// (RULE_11) Flash keeps only positions, parameters, programs.
// (RULE_12) Transfers use only the words they need.
// (RULE_13) Coordinates direct or from table A0000-A1999.
// (RULE_14) Host checks error flag and status bit 14.
// (RULE_15) Accept only processable data, else skip silently.
// (RULE_16) Out-of-range data: discard, bit 14, error code.
// (RULE_17) Hold acceptance until flash done; source must be one.
module fsh_cmd_handler
   import fsh_pkg::*;
#(
   parameter logic [31:0] SAVE_TIMEOUT_CYC = SAVE_MAX_CYC
)(
   input  wire logic        clk,             // System clock, 100 MHz.
   input  wire logic        arst_n,          // Asynchronous reset, active low.
   input  wire logic        psel,            // APB select.
   input  wire logic        penable,         // APB enable.
   input  wire logic        pwrite,          // APB write.
   input  wire logic [7:0]  paddr,           // APB byte address.
   input  wire logic [31:0] pwdata,          // APB write data.
   output logic      [31:0] prdata,          // APB read data.
   output logic             pready,          // APB ready.
   output logic             pslverr,         // APB error on unmapped address.
   input  wire logic        intelligent_write_instruction_valid,      // Intelligent write strobe.
   output logic             intelligent_write_instruction_ready,      // Handler can take a write.
   input  wire logic [15:0] intelligent_write_instruction_code,       // Control code word.
   input  wire logic [15:0] intelligent_write_instruction_dest_unit,  // Destination unit number.
   input  wire logic [15:0] intelligent_write_instruction_dest_count, // Total words transferred.
   input  wire logic [15:0] intelligent_write_instruction_src0,       // First source word.
   input  wire logic [15:0] intelligent_write_instruction_src1,       // Second source word.
   output logic             cmd_accepted,    // Acceptance indication.
   output logic      [15:0] stat_word,       // Status word n+10 or n+18.
   output logic      [15:0] err_word,        // Error word n+11 or n+19.
   output logic             flash_start,     // Starts one flash save.
   output logic      [1:0]  flash_region,    // Region that the save writes.
   input  wire logic        flash_done,      // Flash save finished.
   input  wire logic        pos_req,         // Coordinate resolve request.
   input  wire logic        pos_indirect,    // Coordinate taken from table.
   input  wire logic [10:0] pos_index,       // Position table index.
   input  wire logic [31:0] pos_direct,      // Directly given coordinate.
   output logic      [31:0] pos_coord,       // Direct coordinate out.
   output logic      [10:0] pos_table_addr,  // Table entry to fetch.
   output logic             pos_use_table,   // Use the table entry.
   output logic             pos_ref_err,     // Table index out of range.
   output logic             irq              // Interrupt, active high level.
);

   fsh_state_type  state_q;
   logic [6:0]     cfg_unit_q;
   logic           cfg_4ax_q;
   logic [1:0]     irq_stat_q;
   logic [1:0]     irq_mask_q;
   logic [15:0]    code_q;
   logic [15:0]    dest_unit_q;
   logic [15:0]    dest_count_q;
   logic [15:0]    src0_q;
   logic [15:0]    src1_q;
   logic           err_flag_q;
   logic [15:0]    err_code_q;
   logic           accepted_q;
   logic           start_q;
   logic [1:0]     region_q;
   logic [31:0]    prdata_q;
   logic [15:0]    area_first;
   logic [7:0]     area_words;
   logic [15:0]    unit_max;
   logic           timer_expired;
   logic           fmt_ok;
   logic           src_ok;
   logic           apb_wr;
   logic           apb_mapped;
   logic           ev_done;
   logic           ev_err;
   logic [31:0]    rd_mux;

   fsh_area_map u_area (
      .unit_num   (cfg_unit_q),
      .four_axis  (cfg_4ax_q),
      .area_first (area_first),
      .area_words (area_words),
      .unit_max   (unit_max)
   );

   fsh_save_timer #(
      .LIMIT (SAVE_TIMEOUT_CYC)
   ) u_timer (
      .clk     (clk),
      .arst_n  (arst_n),
      .run     (state_q == ST_SAVE),
      .expired (timer_expired)
   );

   // Unknown codes, including any that would reach monitor or special data, are skipped.
   assign fmt_ok = is_save_code(code_q)                                 // RULE_11
                   && (dest_count_q == SAVE_WORD_COUNT)                 // RULE_03
                   && (dest_unit_q <= unit_max)                         // RULE_04
                   && (dest_unit_q == {9'h000, cfg_unit_q});
   assign src_ok = (src0_q == SRC_WORD_LO) && (src1_q == SRC_WORD_HI); // RULE_05
   assign intelligent_write_instruction_ready = (state_q == ST_IDLE);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         code_q       <= 16'h0;
         dest_unit_q  <= 16'h0;
         dest_count_q <= 16'h0;
         src0_q       <= 16'h0;
         src1_q       <= 16'h0;
      end else if (intelligent_write_instruction_valid && intelligent_write_instruction_ready) begin
         // All five words are captured: code, unit, count and the two source words.
         code_q       <= intelligent_write_instruction_code;
         dest_unit_q  <= intelligent_write_instruction_dest_unit;
         dest_count_q <= intelligent_write_instruction_dest_count;
         src0_q       <= intelligent_write_instruction_src0;                                      // RULE_12
         src1_q       <= intelligent_write_instruction_src1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (intelligent_write_instruction_valid) begin
                  state_q <= ST_CHECK;
               end
            end
            ST_CHECK: begin
               state_q <= (fmt_ok && src_ok) ? ST_SAVE : ST_IDLE;         // RULE_15
            end
            ST_SAVE: begin
               if (flash_done || timer_expired) begin                    // RULE_07
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         accepted_q <= 1'b0;
         start_q    <= 1'b0;
         region_q   <= REGION_POSITION;
      end else begin
         start_q <= 1'b0;
         if (state_q == ST_CHECK && fmt_ok && src_ok) begin
            accepted_q <= 1'b1;                                          // RULE_15
            start_q    <= 1'b1;
            region_q   <= (code_q == CODE_SAVE_POS) ? REGION_POSITION    // RULE_01
                                                    : REGION_PARAM;      // RULE_02
         end else if (state_q == ST_SAVE && (flash_done || timer_expired)) begin
            accepted_q <= 1'b0;                                          // RULE_17
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         err_flag_q <= 1'b0;
         err_code_q <= ERR_NONE;
      end else if (state_q == ST_CHECK && fmt_ok && !src_ok) begin
         err_flag_q <= 1'b1;                                             // RULE_16
         err_code_q <= ERR_SRC_RANGE;                                    // RULE_17
      end else if (state_q == ST_SAVE && timer_expired && !flash_done) begin
         err_flag_q <= 1'b1;
         err_code_q <= ERR_TIMEOUT;
      end else if (intelligent_write_instruction_valid && intelligent_write_instruction_ready) begin
         err_flag_q <= 1'b0;
         err_code_q <= ERR_NONE;
      end
   end

   assign cmd_accepted = accepted_q;
   assign flash_start  = start_q;
   assign flash_region = region_q;
   // Status refreshed toward the host every cycle.
   assign stat_word    = {1'b0, err_flag_q, 12'h000, accepted_q, (state_q == ST_SAVE)}; // RULE_10
   assign err_word     = err_code_q;                                                    // RULE_10

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pos_coord      <= 32'h0;
         pos_table_addr <= 11'h0;
         pos_use_table  <= 1'b0;
         pos_ref_err    <= 1'b0;
      end else if (pos_req) begin
         pos_coord      <= pos_direct;                                   // RULE_13
         pos_table_addr <= pos_index;
         pos_use_table  <= pos_indirect && (pos_index <= POS_TABLE_LAST);
         pos_ref_err    <= pos_indirect && (pos_index > POS_TABLE_LAST); // RULE_13
      end
   end

   // APB: zero wait states; read data is sampled in the setup cycle.
   assign apb_wr     = psel && penable && pwrite;
   assign apb_mapped = (paddr == REG_CFG) || (paddr == REG_STATUS) || (paddr == REG_ERRCODE)
                       || (paddr == REG_AREA) || (paddr == REG_IRQ_STAT) || (paddr == REG_IRQ_MASK);
   assign pready     = psel && penable;
   assign pslverr    = psel && penable && !apb_mapped;
   assign prdata     = prdata_q;
   assign ev_done    = (state_q == ST_SAVE) && flash_done;
   assign ev_err     = ((state_q == ST_CHECK) && fmt_ok && !src_ok)
                       || ((state_q == ST_SAVE) && timer_expired && !flash_done);

   always_comb begin
      case (paddr)
         REG_CFG:      rd_mux = {23'h0, cfg_4ax_q, 1'b0, cfg_unit_q};
         REG_STATUS:   rd_mux = {16'h0, stat_word};
         REG_ERRCODE:  rd_mux = {16'h0, err_code_q};
         REG_AREA:     rd_mux = {8'h0, area_words, area_first};
         REG_IRQ_STAT: rd_mux = {30'h0, irq_stat_q};
         REG_IRQ_MASK: rd_mux = {30'h0, irq_mask_q};
         default:      rd_mux = 32'h0;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         prdata_q <= 32'h0;
      end else if (psel && !penable && !pwrite) begin
         prdata_q <= rd_mux;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_unit_q <= CFG_UNIT_RST;
         cfg_4ax_q  <= CFG_4AX_RST;
         irq_mask_q <= IRQ_MASK_RST;
      end else if (apb_wr && paddr == REG_CFG) begin
         cfg_unit_q <= pwdata[6:0];
         cfg_4ax_q  <= pwdata[CFG_4AX_BIT];
      end else if (apb_wr && paddr == REG_IRQ_MASK) begin
         irq_mask_q <= pwdata[1:0];
      end
   end

   // Write one to clear; a new event in the same cycle keeps its bit set.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_stat_q <= 2'h0;
      end else begin
         irq_stat_q[IRQ_DONE_BIT] <= ev_done
            || (irq_stat_q[IRQ_DONE_BIT] && !(apb_wr && paddr == REG_IRQ_STAT && pwdata[IRQ_DONE_BIT]));
         irq_stat_q[IRQ_ERR_BIT]  <= ev_err
            || (irq_stat_q[IRQ_ERR_BIT] && !(apb_wr && paddr == REG_IRQ_STAT && pwdata[IRQ_ERR_BIT]));
      end
   end

   assign irq = |(irq_stat_q & irq_mask_q);

   property p_good_cmd_starts;
      @(posedge clk) disable iff (!arst_n)
      (state_q == ST_CHECK && fmt_ok && src_ok) |=> flash_start && cmd_accepted && (state_q == ST_SAVE);
   endproperty
   a_good_cmd_starts: assert property (p_good_cmd_starts) else $error("good save not started"); // RULE_15

   property p_bad_fmt_skipped;
      @(posedge clk) disable iff (!arst_n)
      (state_q == ST_CHECK && !fmt_ok) |=> !cmd_accepted && !flash_start && (state_q == ST_IDLE);
   endproperty
   a_bad_fmt_skipped: assert property (p_bad_fmt_skipped) else $error("bad format accepted"); // RULE_04

   property p_region_pos;
      @(posedge clk) disable iff (!arst_n)
      (state_q == ST_CHECK && fmt_ok && src_ok && code_q == CODE_SAVE_POS) |=> flash_region == REGION_POSITION;
   endproperty
   a_region_pos: assert property (p_region_pos) else $error("position save wrong region"); // RULE_01

   property p_region_param;
      @(posedge clk) disable iff (!arst_n)
      (state_q == ST_CHECK && fmt_ok && src_ok && code_q == CODE_SAVE_PARAM) |=> flash_region == REGION_PARAM;
   endproperty
   a_region_param: assert property (p_region_param) else $error("parameter save wrong region"); // RULE_02

   property p_src_range_err;
      @(posedge clk) disable iff (!arst_n)
      (state_q == ST_CHECK && fmt_ok && !src_ok)
         |=> stat_word[STAT_ERR_BIT] && (err_word == ERR_SRC_RANGE) && !cmd_accepted;
   endproperty
   a_src_range_err: assert property (p_src_range_err) else $error("source range error not reported"); // RULE_16

   property p_hold_until_done;
      @(posedge clk) disable iff (!arst_n)
      (cmd_accepted && !flash_done && !timer_expired) |=> cmd_accepted && (state_q == ST_SAVE);
   endproperty
   a_hold_until_done: assert property (p_hold_until_done) else $error("acceptance dropped early"); // RULE_17

   property p_done_releases;
      @(posedge clk) disable iff (!arst_n)
      (state_q == ST_SAVE && flash_done) |=> !cmd_accepted && (state_q == ST_IDLE) && irq_stat_q[IRQ_DONE_BIT];
   endproperty
   a_done_releases: assert property (p_done_releases) else $error("completion not handled"); // RULE_17

   property p_timeout_err;
      @(posedge clk) disable iff (!arst_n)
      (state_q == ST_SAVE && timer_expired && !flash_done) |=> (err_word == ERR_TIMEOUT) && stat_word[STAT_ERR_BIT];
   endproperty
   a_timeout_err: assert property (p_timeout_err) else $error("save timeout not reported"); // RULE_07

   property p_area_first;
      @(posedge clk) disable iff (!arst_n)
      1'b1 |-> (rd_mux[15:0] == 16'(AREA_BASE + AREA_STEP * {9'h000, cfg_unit_q})) || (paddr != REG_AREA);
   endproperty
   a_area_first: assert property (p_area_first) else $error("area base word wrong"); // RULE_08

   property p_area_words;
      @(posedge clk) disable iff (!arst_n)
      (paddr == REG_AREA) |-> rd_mux[23:16] == (cfg_4ax_q ? AREA_WORDS_4AX : AREA_WORDS_2AX);
   endproperty
   a_area_words: assert property (p_area_words) else $error("area size wrong"); // RULE_09

   property p_pos_range;
      @(posedge clk) disable iff (!arst_n)
      (pos_req && pos_indirect && pos_index > POS_TABLE_LAST) |=> pos_ref_err && !pos_use_table;
   endproperty
   a_pos_range: assert property (p_pos_range) else $error("table index range not flagged"); // RULE_13

   c_pos_save:   cover property (@(posedge clk) disable iff (!arst_n) flash_start && flash_region == REGION_POSITION);
   c_param_save: cover property (@(posedge clk) disable iff (!arst_n) flash_start && flash_region == REGION_PARAM);
   c_src_error:  cover property (@(posedge clk) disable iff (!arst_n) $rose(stat_word[STAT_ERR_BIT]));
   c_irq:        cover property (@(posedge clk) disable iff (!arst_n) $rose(irq));

endmodule

// ---- src/fsh_save_timer.sv ----
// Watchdog that bounds how long one flash save may run.
`timescale 1ns/1ps
module fsh_save_timer
   import fsh_pkg::*;
#(
   parameter logic [31:0] LIMIT = SAVE_MAX_CYC
)(
   input  wire logic clk,     // System clock.
   input  wire logic arst_n,  // Asynchronous reset, active low.
   input  wire logic run,     // High while a save is in progress.
   output logic      expired  // High from the LIMIT-th cycle of a save onward.
);

   logic [31:0] cnt_q;

   // Elaboration refuses a limit that would expire on the first cycle of a save.
   if (LIMIT < 32'h2) begin : g_limit_check
      $error("fsh_save_timer: LIMIT must be at least 2");
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= 32'h0;
      end else if (!run) begin
         cnt_q <= 32'h0;
      end else if (!expired) begin
         cnt_q <= cnt_q + 32'h1;
      end
   end

   assign expired = run && (cnt_q == LIMIT - 32'h1);

endmodule

// ---- tb/fsh_cmd_handler_tb.sv ----
// Self-checking bench for the flash save command handler.
`timescale 1ns/1ps
module fsh_cmd_handler_tb
   import fsh_pkg::*;
;
   localparam logic [15:0] CP = CODE_SAVE_POS;
   localparam logic [15:0] CQ = CODE_SAVE_PARAM;
   localparam logic [15:0] WC = SAVE_WORD_COUNT;
   logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, irq, se, f, ind;
   logic        intelligent_write_instruction_valid, intelligent_write_instruction_ready, req, cmd_accepted, flash_start, flash_done;
   logic        pos_req, pos_indirect, pos_use_table, pos_ref_err;
   logic [7:0]  paddr;
   logic [6:0]  u7;
   logic [1:0]  flash_region, m;
   logic [10:0] pos_index, pos_table_addr, idx;
   logic [15:0] stat_word, err_word;
   logic [31:0] pwdata, prdata, rd, pos_direct, pos_coord, dir;
   logic [79:0] req_words, words;
   int          num_errors = 0;
   int          checks = 0;

   fsh_host_model i_fsh_host_model (.clk, .arst_n, .req, .req_words, .intelligent_write_instruction_ready, .intelligent_write_instruction_valid, .words_q(words));
   fsh_cmd_handler #(.SAVE_TIMEOUT_CYC(32'h14)) i_fsh_cmd_handler (
      .clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .intelligent_write_instruction_valid, .intelligent_write_instruction_ready, .intelligent_write_instruction_code(words[79:64]), .intelligent_write_instruction_dest_unit(words[63:48]),
      .intelligent_write_instruction_dest_count(words[47:32]), .intelligent_write_instruction_src0(words[31:16]), .intelligent_write_instruction_src1(words[15:0]),
      .cmd_accepted, .stat_word, .err_word, .flash_start, .flash_region, .flash_done,
      .pos_req, .pos_indirect, .pos_index, .pos_direct, .pos_coord, .pos_table_addr,
      .pos_use_table, .pos_ref_err, .irq);

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   function automatic logic [31:0] area_exp(input logic [6:0] u, input logic four);
      return {8'h0, four ? 8'h32 : 8'h1e, 16'h07d0 + 16'h000a * {9'h0, u}};
   endfunction

   function automatic logic [1:0] exp_irq(input int kind);
      return kind == 1 ? 2'h1 : (kind >= 2 ? 2'h2 : 2'h0);
   endfunction

   function automatic logic [15:0] exp_err(input int kind);
      return kind == 2 ? ERR_SRC_RANGE : (kind == 3 ? ERR_TIMEOUT : ERR_NONE);
   endfunction

   task automatic print_verdict;
      $display("checks %0d, mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s: expected %h, seen %h", n, exp, got);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 16);
      if (k >= 16) num_errors++;
      rd = prdata;
      se = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic save(input logic [15:0] c, u, n, s0, s1, input int kind);
      int k;
      @(posedge clk);
      req_words <= {c, u, n, s0, s1};
      req       <= 1'b1;
      @(posedge clk);
      req <= 1'b0;
      k = 0;
      while (!(intelligent_write_instruction_valid && intelligent_write_instruction_ready) && k < 16) begin
         @(negedge clk);
         k++;
      end
      repeat (2) @(posedge clk);
      #1;
      chk("accepted", cmd_accepted, kind == 1 || kind == 3);
      chk("ready", intelligent_write_instruction_ready, !(kind == 1 || kind == 3));
      chk("start", flash_start, kind == 1 || kind == 3);
      if (kind == 1) chk("region", flash_region, c == CQ ? 2'h1 : 2'h0);
      chk("status", stat_word, kind == 2 ? 16'h4000 : (kind == 0 ? 16'h0 : 16'h0003));
      chk("error", err_word, exp_err(kind == 2 ? 2 : 0));
      if (kind == 1) begin
         repeat ($urandom_range(4) + 1) @(posedge clk);
         chk("held", cmd_accepted, 1);
         flash_done <= 1'b1;
         @(posedge clk);
         flash_done <= 1'b0;
      end else if (kind == 3) begin
         k = 0;
         while (err_word !== ERR_TIMEOUT && k < 40) begin
            @(posedge clk);
            #1;
            k++;
         end
         chk("limit", k > 14 && k < 26, 1);
      end
      #1;
      chk("released", cmd_accepted, 0);
      chk("stat_end", stat_word, kind >= 2 ? 16'h4000 : 16'h0);
      chk("irq", irq, |(exp_irq(kind) & m));
      apb(1'b0, REG_IRQ_STAT, 32'h0);
      chk("irq_stat", rd, {30'h0, exp_irq(kind)});
      apb(1'b1, REG_IRQ_STAT, 32'h3);
      apb(1'b0, REG_ERRCODE, 32'h0);
      chk("errcode", rd, {16'h0, exp_err(kind)});
      chk("irq_clr", irq, 0);
   endtask

   task automatic run(input logic [6:0] cu, input logic four, input logic [15:0] c, u, n, s0, s1, input int kind);
      m = 2'($urandom);
      apb(1'b1, REG_CFG, {23'h0, four, 1'b0, cu});
      apb(1'b1, REG_IRQ_MASK, {30'h0, m});
      save(c, u, n, s0, s1, kind);
   endtask

   initial begin
      #200_000;
      num_errors++;
      print_verdict();
   end

   initial begin
      void'($urandom(78724));
      arst_n       = 1'b0;
      psel         = 1'b0;
      penable      = 1'b0;
      pwrite       = 1'b0;
      paddr        = 8'h0;
      pwdata       = 32'h0;
      req          = 1'b0;
      req_words    = 80'h0;
      flash_done   = 1'b0;
      pos_req      = 1'b0;
      pos_indirect = 1'b0;
      pos_index    = 11'h0;
      pos_direct   = 32'h0;
      m            = 2'h0;
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      apb(1'b0, REG_CFG, 32'h0);
      chk("cfg_rst", rd, 32'h0000_0100);
      apb(1'b0, REG_IRQ_MASK, 32'h0);
      chk("mask_rst", rd, 32'h0);
      apb(1'b0, REG_AREA, 32'h0);
      chk("area_rst", rd, area_exp(7'h0, 1'b1));
      apb(1'b0, 8'h3c, 32'h0);
      chk("slverr", se, 1);
      chk("unmapped", rd, 32'h0);
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         u7 = 7'($urandom_range(93));
         f  = 1'($urandom);
         apb(1'b1, REG_CFG, {23'h0, f, 1'b0, u7});
         apb(1'b0, REG_AREA, 32'h0);
         chk("area", rd, area_exp(u7, f));
      end
      $display("test area done");
      run(7'h5c, 1'b1, CP, 16'h5c, WC, 16'h1, 16'h0, 0);
      run(7'h5c, 1'b0, CP, 16'h5c, WC, 16'h1, 16'h0, 1);
      run(7'h5e, 1'b0, CQ, 16'h5e, WC, 16'h1, 16'h0, 0);
      run(7'h05, 1'b1, 16'h17d6, 16'h5, WC, 16'h1, 16'h0, 0);
      run(7'h05, 1'b1, CP, 16'h5, 16'h3, 16'h1, 16'h0, 0);
      run(7'h05, 1'b1, CP, 16'h6, WC, 16'h1, 16'h0, 0);
      run(7'h05, 1'b1, CP, 16'h5, WC, 16'h2, 16'h0, 2);
      run(7'h05, 1'b1, CQ, 16'h5, WC, 16'h1, 16'h1, 2);
      run(7'h05, 1'b1, CQ, 16'h5, WC, 16'h1, 16'h0, 3);
      for (int i = 0; i < 8; i++) begin
         u7 = 7'($urandom_range(91));
         run(u7, 1'($urandom), i[0] ? CQ : CP, {9'h0, u7}, WC, 16'h1, 16'h0, 1);
      end
      $display("test save done");
      for (int i = 0; i < 6; i++) begin
         ind = (i < 2) | i[0];
         idx = i == 0 ? 11'h7cf : (i == 1 ? 11'h7d0 : 11'($urandom));
         dir = $urandom;
         @(posedge clk);
         pos_req      <= 1'b1;
         pos_indirect <= ind;
         pos_index    <= idx;
         pos_direct   <= dir;
         @(posedge clk);
         pos_req <= 1'b0;
         #1;
         chk("use_table", pos_use_table, ind && idx <= POS_TABLE_LAST);
         chk("ref_err", pos_ref_err, ind && idx > 11'h7cf);
         if (ind) chk("table_addr", pos_table_addr, idx);
         else chk("coord", pos_coord, dir);
      end
      $display("test position done");
      print_verdict();
   end
endmodule

// ---- tb/fsh_host_model.sv ----
// Host-side model that issues intelligent writes to the handler.
`timescale 1ns/1ps
module fsh_host_model (
   input  wire logic        clk,        // System clock.
   input  wire logic        arst_n,     // Reset, active low.
   input  wire logic        req,        // Issue one write.
   input  wire logic [79:0] req_words,  // Code, unit, count, src0, src1.
   input  wire logic        intelligent_write_instruction_ready, // Handler can take a write.
   output logic             intelligent_write_instruction_valid, // Write request.
   output logic      [79:0] words_q     // Words on the bus.
);
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         intelligent_write_instruction_valid <= 1'b0;
         words_q    <= '0;
      end else if (intelligent_write_instruction_valid && intelligent_write_instruction_ready) begin
         intelligent_write_instruction_valid <= 1'b0;
         // Released words flip so a stale value never passes for data.
         words_q    <= ~words_q;
      end else if (req && !intelligent_write_instruction_valid) begin
         intelligent_write_instruction_valid <= 1'b1;
         words_q    <= req_words;
      end
   end
endmodule
